// ### hw/ioia_pkg.sv
// Shared constants of the interrupt aggregator: line layout, decode, timing.
// Assumes a single 25 MHz clock and a synchronous active-low reset.
package ioia_pkg;
    // Request line positions in status and mask
    localparam int unsigned LINES = 8;
    localparam int unsigned BIT_PPI0 = 0; // Four parallel-port lines 0..3
    localparam int unsigned BIT_SER_RX = 4; // Serial receive buffer full
    localparam int unsigned BIT_SER_TX = 5; // Serial transmit buffer empty
    localparam int unsigned BIT_EXT0 = 6; // Connector line 0
    localparam int unsigned BIT_EXT1 = 7; // Connector line 1 or interval timer
    // Low address digit of each register; high digit from the base jumpers
    localparam logic [3:0] LO_STATUS = 4'h0;
    localparam logic [3:0] LO_MASK = 4'h1;
    // Reset values
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Interval timer timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TMR_110_NS = 1003000;
    localparam int unsigned TMR_STD_NS = 1042000;
    localparam int unsigned TMR_110_CYC = TMR_110_NS / CLK_PERIOD_NS;
    localparam int unsigned TMR_STD_CYC = TMR_STD_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 15;
endpackage

// ### hw/ioia_tick_if.sv
// Carries the interval tick and its rate choice between the timer and the top.
// Assumes both ends share the one system clock.
`timescale 1ns/100ps
interface ioia_tick_if;
    logic sel_110; // Low baud rate selected
    logic tick; // One-cycle interval pulse
    modport gen (input sel_110, output tick);
    modport use_end (output sel_110, input tick);
endinterface

// ### hw/ioia_tick_gen.sv
// Interval timer divider sitting beside the baud generator.
// Assumes a free-running system clock; period counts come from the top.
`timescale 1ns/100ps
module ioia_tick_gen
    import ioia_pkg::*;
#(
    parameter logic [CNT_W-1:0] CYC_110 = CNT_W'(TMR_110_CYC),
    parameter logic [CNT_W-1:0] CYC_STD = CNT_W'(TMR_STD_CYC)
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    ioia_tick_if.gen tk
);
    // Whole state of the divider
    typedef struct packed {
        logic [CNT_W-1:0] cnt; // Cycles since last tick
        logic tick; // Registered pulse
    } ioia_tick_s;

    ioia_tick_s st_ff;
    ioia_tick_s nxt_st;
    logic [CNT_W-1:0] limit; // Period of the selected rate

    // Period follows the baud selection
    assign limit = tk.sel_110 ? CYC_110 : CYC_STD;

    // Divider: wrap and pulse at the end of each period
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= limit - CNT_W'(1)) begin // Also catches a rate change mid-count
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick = st_ff.tick;

    // Helper: a tick was seen since reset
    logic seen_ff;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            seen_ff <= 1'b0;
        end else if (st_ff.tick) begin
            seen_ff <= 1'b1;
        end
    end

    // Rate held across the wrap: the count that wrapped was the last of its period
    property p_tick_period;
        @(posedge clk_in) disable iff (!rst_n_in)
        (st_ff.tick && seen_ff && $stable(tk.sel_110) && $past(tk.sel_110, 2) == tk.sel_110)
            |-> st_ff.cnt == '0 && $past(st_ff.cnt) == $past(limit) - CNT_W'(1);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("Tick not at period wrap");

    property p_tick_single;
        @(posedge clk_in) disable iff (!rst_n_in)
        st_ff.tick |=> !st_ff.tick [*8];
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("Tick repeated too soon");
endmodule // ioia_tick_gen

// ### hw/ioia_top.sv
// Interrupt aggregator of a combination I/O board: eight request lines,
// status and mask registers on a small I/O port, routing toward the host.
// Assumes all inputs synchronous to clk_in; one access per strobe cycle.
// Summary of operation
// - Eight separate request lines, each its own
// - Four lines from parallel port buffer events
// - Two lines from serial receive/transmit buffers
// - Controller lines maskable, masked gives no request
// - Status register holds all eight line states
// - Each line has its own mask bit
// - Jumper-enabled one millisecond interval timer request
// - Status at base digit 0, mask at 1
// - Lines ORed to one, or driven individually
// - Timer from baud generator replaces connector line
// - Period 1.003 ms at 110 baud, else 1.042
`timescale 1ns/100ps
module ioia_top
    import ioia_pkg::*;
#(
    parameter int unsigned TICK_110_CYC = TMR_110_CYC,
    parameter int unsigned TICK_STD_CYC = TMR_STD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] ppi_req_in,
    input wire logic ser_rx_full_in,
    input wire logic ser_tx_empty_in,
    input wire logic [1:0] ext_req_in,
    input wire logic timer_jumper_in,
    input wire logic baud_110_in,
    input wire logic route_or_in,
    input wire logic [3:0] base_sel_in,
    input wire logic [7:0] io_addr_in,
    input wire logic io_rd_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_ack_out,
    output logic host_irq_out,
    output logic [7:0] bus_irq_out
);
    // Whole state of the aggregator
    typedef struct packed {
        logic [7:0] status; // Current line states
        logic [7:0] mask; // One suppresses a line
        logic tmr_flag; // Interval request, held until status read
        logic [7:0] rdata; // Read data
        logic ack; // Access answered
        logic host_irq; // Combined request
        logic [7:0] bus_irq; // Individual requests
    } ioia_state_s;

    ioia_state_s st_ff;
    ioia_state_s nxt_st;
    logic [7:0] raw; // Line states before latching
    logic [7:0] enabled; // Active and unmasked lines
    logic hit_status; // Access decodes to status
    logic hit_mask; // Access decodes to mask
    logic new_tmr; // Next interval flag

    ioia_tick_if tk ();
    assign tk.sel_110 = baud_110_in;

    ioia_tick_gen #(
        .CYC_110(CNT_W'(TICK_110_CYC)),
        .CYC_STD(CNT_W'(TICK_STD_CYC))
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tk(tk)
    );

    // Address match on jumpered high digit and given low digit
    function automatic logic addr_hit(input logic [7:0] addr, input logic [3:0] base, input logic [3:0] lo);
        return addr == {base, lo};
    endfunction

    assign hit_status = addr_hit(io_addr_in, base_sel_in, LO_STATUS);
    assign hit_mask = addr_hit(io_addr_in, base_sel_in, LO_MASK);

    // Interval flag: a tick in the reading cycle wins over the clear
    assign new_tmr = tk.tick | (st_ff.tmr_flag & ~(io_rd_in & hit_status));

    // Gather the eight sources into their fixed positions
    always_comb begin
        raw = ZERO8;
        raw[BIT_PPI0 +: 4] = ppi_req_in;
        raw[BIT_SER_RX] = ser_rx_full_in;
        raw[BIT_SER_TX] = ser_tx_empty_in;
        raw[BIT_EXT0] = ext_req_in[0];
        // Jumper swaps the connector line for the timer
        raw[BIT_EXT1] = timer_jumper_in ? new_tmr : ext_req_in[1];
    end

    assign enabled = st_ff.status & ~st_ff.mask;

    // Next state: latch lines, serve accesses, route requests
    always_comb begin
        nxt_st = st_ff;
        nxt_st.status = raw;
        nxt_st.tmr_flag = timer_jumper_in & new_tmr;
        nxt_st.ack = io_rd_in | io_wr_in;
        if (io_wr_in && hit_mask) begin
            nxt_st.mask = io_wdata_in;
        end
        if (io_rd_in) begin
            if (hit_status) begin
                nxt_st.rdata = st_ff.status;
            end else if (hit_mask) begin
                nxt_st.rdata = st_ff.mask;
            end else begin // Unmapped reads as zero
                nxt_st.rdata = ZERO8;
            end
        end
        // Routing jumper: one combined line, or one line each
        if (route_or_in) begin
            nxt_st.host_irq = |enabled;
            nxt_st.bus_irq = ZERO8;
        end else begin
            nxt_st.host_irq = 1'b0;
            nxt_st.bus_irq = enabled;
        end
    end

    // State register; mask comes up with every line suppressed
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.mask <= MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata_out = st_ff.rdata;
    assign io_ack_out = st_ff.ack;
    assign host_irq_out = st_ff.host_irq;
    assign bus_irq_out = st_ff.bus_irq;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_status_track;
        !timer_jumper_in |=> st_ff.status == $past({ext_req_in, ser_tx_empty_in, ser_rx_full_in, ppi_req_in});
    endproperty
    a_status_track: assert property (p_status_track) else $error("Status does not follow lines");

    property p_mask_write;
        (io_wr_in && io_addr_in == {base_sel_in, LO_MASK}) |=> st_ff.mask == $past(io_wdata_in);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("Mask write lost");

    property p_status_read;
        (io_rd_in && io_addr_in == {base_sel_in, LO_STATUS}) |=> io_rdata_out == $past(st_ff.status) && io_ack_out;
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read wrong");

    property p_or_route;
        (route_or_in && (st_ff.status & ~st_ff.mask) != ZERO8) |=> host_irq_out && bus_irq_out == ZERO8;
    endproperty
    a_or_route: assert property (p_or_route) else $error("Combined request missing");

    property p_indiv_route;
        !route_or_in |=> !host_irq_out && bus_irq_out == $past(st_ff.status & ~st_ff.mask);
    endproperty
    a_indiv_route: assert property (p_indiv_route) else $error("Individual routing wrong");

    property p_masked_quiet;
        ((st_ff.status & ~st_ff.mask) == ZERO8) |=> !host_irq_out && bus_irq_out == ZERO8;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("Masked line requested");

    property p_timer_sub;
        (timer_jumper_in && tk.tick) |=> st_ff.status[BIT_EXT1] && st_ff.tmr_flag;
    endproperty
    a_timer_sub: assert property (p_timer_sub) else $error("Interval tick not latched");

    property p_ext_direct;
        !timer_jumper_in |=> st_ff.status[BIT_EXT1] == $past(ext_req_in[1]) && !st_ff.tmr_flag;
    endproperty
    a_ext_direct: assert property (p_ext_direct) else $error("Connector line not passed");

    // Every access cycle is answered on the next edge, and only then
    property p_ack_on_access;
        (io_rd_in || io_wr_in) |=> io_ack_out;
    endproperty
    a_ack_on_access: assert property (p_ack_on_access) else $error("Access not answered");

    property p_ack_idle;
        !(io_rd_in || io_wr_in) |=> !io_ack_out;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("Answer without access");

    property p_mask_read;
        (io_rd_in && io_addr_in == {base_sel_in, LO_MASK}) |=> io_rdata_out == $past(st_ff.mask);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("Mask read wrong");

    // Stray reads return zero, so a probe of a neighbour port sees no request
    property p_unmapped_zero;
        (io_rd_in && io_addr_in != {base_sel_in, LO_STATUS} && io_addr_in != {base_sel_in, LO_MASK})
            |=> io_rdata_out == ZERO8;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero");

    // Read data is registered, so it holds between reads
    property p_rdata_hold;
        !io_rd_in |=> $stable(io_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved without read");

    property p_mask_hold;
        !(io_wr_in && io_addr_in == {base_sel_in, LO_MASK}) |=> $stable(st_ff.mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("Mask changed without write");

    // Interval request stays up until software reads status
    property p_tmr_hold;
        (timer_jumper_in && st_ff.tmr_flag && !(io_rd_in && io_addr_in == {base_sel_in, LO_STATUS}))
            |=> st_ff.tmr_flag && st_ff.status[BIT_EXT1];
    endproperty
    a_tmr_hold: assert property (p_tmr_hold) else $error("Interval request dropped early");

    property p_tmr_clear;
        (timer_jumper_in && st_ff.tmr_flag && !tk.tick && io_rd_in && io_addr_in == {base_sel_in, LO_STATUS})
            |=> !st_ff.tmr_flag && !st_ff.status[BIT_EXT1];
    endproperty
    a_tmr_clear: assert property (p_tmr_clear) else $error("Interval request not cleared by read");

    property p_or_bus_quiet;
        route_or_in |=> bus_irq_out == ZERO8;
    endproperty
    a_or_bus_quiet: assert property (p_or_bus_quiet) else $error("Individual lines driven while combined");
endmodule // ioia_top

// ### dv/ioia_host_model.sv
// Host processor model: reads and writes the interrupt registers.
// Assumes the register port is sampled on clk_in rising edges.
`timescale 1ns/100ps
module ioia_host_model (
    input wire logic clk_in,
    input wire logic [7:0] io_rdata_in,
    input wire logic io_ack_in,
    output logic [7:0] io_addr_out,
    output logic io_rd_out,
    output logic io_wr_out,
    output logic [7:0] io_wdata_out
);
    // Idle bus shows no stale address or data
    initial begin
        io_addr_out = 8'hFF;
        io_rd_out = 1'b0;
        io_wr_out = 1'b0;
        io_wdata_out = 8'h00;
    end
    // One-cycle read; answer taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic k);
        @(negedge clk_in);
        io_addr_out = a;
        io_rd_out = 1'b1;
        @(negedge clk_in);
        io_rd_out = 1'b0;
        io_addr_out = ~a;
        d = io_rdata_in;
        k = io_ack_in;
    endtask
    // One-cycle write; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_in);
        io_addr_out = a;
        io_wdata_out = v;
        io_wr_out = 1'b1;
        @(negedge clk_in);
        io_wr_out = 1'b0;
        io_addr_out = ~a;
        io_wdata_out = ~v;
    endtask
endmodule // ioia_host_model

// ### dv/ioia_top_tb.sv
// Self-checking bench of the interrupt aggregator.
// Assumes shortened timer counts; inputs change at falling edges.
`timescale 1ns/100ps
module ioia_top_tb;
    import ioia_pkg::*;
    localparam int unsigned P110 = 20;
    localparam int unsigned PSTD = 24;
    logic clk_in = 1'b0, rst_n_in = 1'b0, rx = 1'b0, tx = 1'b0, jmp = 1'b0, b110 = 1'b0, ror = 1'b0;
    logic [3:0] ppi = 4'h0, base = 4'h3;
    logic [1:0] ext = 2'h0;
    logic [7:0] addr, wdata, rdata, bus_irq, d;
    logic rd, wr, ack, host_irq, k;
    int fails = 0, checks = 0, cyc = 0;
    // 25 MHz clock and cycle count
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    ioia_top #(.TICK_110_CYC(P110), .TICK_STD_CYC(PSTD)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ppi_req_in(ppi), .ser_rx_full_in(rx), .ser_tx_empty_in(tx), .ext_req_in(ext),
        .timer_jumper_in(jmp), .baud_110_in(b110), .route_or_in(ror), .base_sel_in(base),
        .io_addr_in(addr), .io_rd_in(rd), .io_wr_in(wr), .io_wdata_in(wdata), .io_rdata_out(rdata),
        .io_ack_out(ack), .host_irq_out(host_irq), .bus_irq_out(bus_irq));
    ioia_host_model i_host (.clk_in(clk_in), .io_rdata_in(rdata), .io_ack_in(ack), .io_addr_out(addr),
        .io_rd_out(rd), .io_wr_out(wr), .io_wdata_out(wdata));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register read with its acknowledge checked too
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        i_host.rd(a, d, k);
        chk("ack", 8'h01, {7'h00, k});
        chk(nm, e, d);
    endtask
    // Drive all eight source lines, then let status and outputs settle
    task automatic lines(input logic [7:0] v);
        @(negedge clk_in);
        {ext, tx, rx, ppi} = v;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic t_reset();
        chk("bus_irq", 8'h00, bus_irq);
        chk("host_irq", 8'h00, {7'h00, host_irq});
        rdc({base, LO_MASK}, 8'hFF, "mask");
        rdc({base, LO_STATUS}, 8'h00, "status");
    endtask
    // Each line alone lands in its own status bit
    task automatic t_status();
        for (int i = 0; i < 8; i++) begin
            lines(8'h01 << i);
            rdc({base, LO_STATUS}, 8'h01 << i, "status");
        end
        lines(8'h00);
    endtask
    // One enabled line among all active ones
    task automatic t_mask();
        for (int i = 0; i < 8; i++) begin
            ror = 1'b0;
            i_host.wr({base, LO_MASK}, ~(8'h01 << i));
            lines(8'hFF);
            chk("bus_irq", 8'h01 << i, bus_irq);
            ror = 1'b1;
            lines(8'h01 << i);
            chk("host_irq", 8'h01, {7'h00, host_irq});
            chk("bus_irq", 8'h00, bus_irq);
            lines(~(8'h01 << i));
            chk("host_irq", 8'h00, {7'h00, host_irq});
        end
        ror = 1'b0;
        i_host.wr({base, LO_MASK}, 8'hFF);
        lines(8'h00);
    endtask
    // Status not writable, other addresses and bases ignored
    task automatic t_decode();
        i_host.wr({base, LO_STATUS}, 8'h00);
        i_host.wr({~base, LO_MASK}, 8'h00);
        rdc({base, LO_MASK}, 8'hFF, "mask");
        rdc({base, 4'h2}, 8'h00, "unmapped");
        rdc({~base, LO_STATUS}, 8'h00, "other base");
        // Moved base jumper: registers follow it, old base goes dead
        base = 4'hA;
        i_host.wr({base, LO_MASK}, 8'hA5);
        rdc({base, LO_MASK}, 8'hA5, "moved mask");
        rdc({4'h3, LO_MASK}, 8'h00, "old base");
        i_host.wr({base, LO_MASK}, 8'hFF);
        base = 4'h3;
    endtask
    task automatic wait_b7(input logic v);
        int n;
        n = 0;
        while (bus_irq[7] !== v && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 200) begin
            fails++;
            $display("unexpected timer request expected %b seen %b", v, bus_irq[7]);
        end
    endtask
    // Interval between two timer requests, after settling at the new rate
    task automatic t_timer(input logic b, input int unsigned per);
        int t0;
        t0 = 0;
        jmp = 1'b1;
        b110 = b;
        i_host.wr({base, LO_MASK}, 8'h7F);
        for (int j = 0; j < 3; j++) begin
            wait_b7(1'b1);
            if (j == 2) chk("timer period", 8'(per), 8'(cyc - t0));
            t0 = cyc;
            rdc({base, LO_STATUS}, 8'h80, "timer status");
            wait_b7(1'b0);
        end
        jmp = 1'b0;
        repeat (60) @(negedge clk_in);
        chk("bus_irq", 8'h00, bus_irq);
    endtask
    task automatic print_verdict();
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        t_reset();
        t_status();
        t_mask();
        t_decode();
        t_timer(1'b1, P110);
        t_timer(1'b0, PSTD);
        print_verdict();
    end
endmodule // ioia_top_tb
